// file: design/tick_wdog_pkg.sv
package tick_wdog_pkg;
  // byte addresses on the register bus
  localparam logic [4:0] OFS_CONFIG = 5'h00;
  localparam logic [4:0] OFS_PRESCALE = 5'h04;
  localparam logic [4:0] OFS_RELOAD = 5'h08;
  localparam logic [4:0] OFS_CTRL = 5'h0C;
  localparam logic [4:0] OFS_WDCOUNT = 5'h10;
  localparam logic [4:0] OFS_KEY = 5'h14;
  // config bit positions
  localparam int CFG_LOCK_CFG = 0;
  localparam int CFG_LOCK_PRE = 1;
  localparam int CFG_LOCK_TMR = 2;
  localparam int CFG_LOCK_WDC = 3;
  localparam int CFG_CLK_SEL = 4;
  localparam int CFG_KEY_EN = 5;
  localparam logic [5:0] CFG_RST = 6'h00;
  // control/status bit positions
  localparam int CSR_RESTART = 0;
  localparam int CSR_FLAG = 1;
  localparam int CSR_IRQ_EN = 2;
  // reset values and constants
  localparam logic [2:0] DIV_RST = 3'h0;
  localparam logic [15:0] RELOAD_RST = 16'hFFFF;
  localparam logic [7:0] WDCOUNT_RST = 8'h0F;
  localparam logic [7:0] SERVICE_KEY = 8'h5C;
  localparam logic [4:0] PRE_MAX_MASK = 5'h1F;
  localparam logic [15:0] TMR_ONE = 16'h0001;
  localparam logic [7:0] WD_ONE = 8'h01;
endpackage

// file: design/tick_wdog_timer.sv
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
module tick_wdog_timer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // slow clock, sampled as a level
  input wire logic low_speed_clock,
  // avalon-mm slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // events
  output logic tick_irq,
  output logic tick_underflow_pulse,
  output logic wdog_reset_req
);
  logic slow_q_ff, waitreq_ff, tick_irq_ff, under_ff, wd_err_ff;
  logic wd_started_ff, serviced_ff, restart_ff, flag_ff, irq_en_ff;
  logic [31:0] rdata_ff;
  logic [5:0] cfg_ff;
  logic [2:0] div_ff;
  logic [4:0] pre_cnt_ff;
  logic [15:0] reload_ff, tmr_cnt_ff;
  logic [7:0] wd_reload_ff, wd_cnt_ff;
  logic slow_edge, tick_en, zero_evt, wd_edge, acc_wr, cap_rd;
  logic wr_cfg, wr_pre, wr_rel_lo, wr_rel_hi, wr_ctrl, wr_wdc, wr_key;
  logic key_ok, key_bad, key_double, wd_zero, rd_ctrl;
  logic [4:0] mask;
  logic [7:0] wbyte;

  assign readdata = rdata_ff;
  assign waitrequest = waitreq_ff;
  assign tick_irq = tick_irq_ff;
  assign tick_underflow_pulse = under_ff;
  assign wdog_reset_req = wd_err_ff;

  // bus strobes: capture on first cycle, commit when waitrequest low
  assign acc_wr = write && !waitreq_ff;
  assign cap_rd = read && waitreq_ff;
  assign wbyte = writedata[7:0];
  assign wr_cfg = acc_wr && byteenable[0] && address == tick_wdog_pkg::OFS_CONFIG
                  && !cfg_ff[tick_wdog_pkg::CFG_LOCK_CFG];
  assign wr_pre = acc_wr && byteenable[0] && address == tick_wdog_pkg::OFS_PRESCALE
                  && !cfg_ff[tick_wdog_pkg::CFG_LOCK_PRE];
  assign wr_rel_lo = acc_wr && byteenable[0] && address == tick_wdog_pkg::OFS_RELOAD
                     && !cfg_ff[tick_wdog_pkg::CFG_LOCK_TMR];
  assign wr_rel_hi = acc_wr && byteenable[1] && address == tick_wdog_pkg::OFS_RELOAD
                     && !cfg_ff[tick_wdog_pkg::CFG_LOCK_TMR];
  assign wr_ctrl = acc_wr && byteenable[0] && address == tick_wdog_pkg::OFS_CTRL
                   && !cfg_ff[tick_wdog_pkg::CFG_LOCK_TMR];
  assign wr_wdc = acc_wr && byteenable[0] && address == tick_wdog_pkg::OFS_WDCOUNT
                  && !cfg_ff[tick_wdog_pkg::CFG_LOCK_WDC];
  assign wr_key = acc_wr && byteenable[0] && address == tick_wdog_pkg::OFS_KEY;
  assign rd_ctrl = cap_rd && address == tick_wdog_pkg::OFS_CTRL
                   && !cfg_ff[tick_wdog_pkg::CFG_LOCK_TMR];

  // key writes count only when enabled
  assign key_ok = wr_key && cfg_ff[tick_wdog_pkg::CFG_KEY_EN]
                  && wbyte == tick_wdog_pkg::SERVICE_KEY;
  assign key_bad = wr_key && cfg_ff[tick_wdog_pkg::CFG_KEY_EN]
                   && wbyte != tick_wdog_pkg::SERVICE_KEY;
  // second key write in one wdog clock
  assign key_double = wr_key && cfg_ff[tick_wdog_pkg::CFG_KEY_EN] && serviced_ff;

  // divisor as low-bit mask, reserved codes act as 32
  always_comb begin
    case (div_ff)
      3'h0: mask = 5'h00;
      3'h1: mask = 5'h01;
      3'h2: mask = 5'h03;
      3'h3: mask = 5'h07;
      3'h4: mask = 5'h0F;
      default: mask = tick_wdog_pkg::PRE_MAX_MASK;
    endcase
  end

  assign slow_edge = low_speed_clock && !slow_q_ff;
  assign tick_en = slow_edge && ((pre_cnt_ff & mask) == mask);
  assign zero_evt = tick_en && !restart_ff && tmr_cnt_ff == tick_wdog_pkg::TMR_ONE;
  assign wd_edge = cfg_ff[tick_wdog_pkg::CFG_CLK_SEL] ? tick_en : zero_evt;
  assign wd_zero = wd_edge && wd_started_ff && !wr_wdc && !key_ok
                   && wd_cnt_ff <= tick_wdog_pkg::WD_ONE;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      slow_q_ff <= 1'b0;
      pre_cnt_ff <= 5'h00;
    end else begin
      slow_q_ff <= low_speed_clock;
      if (slow_edge) begin
        pre_cnt_ff <= pre_cnt_ff + 5'h01;
      end
    end
  end

  // bus handshake: one wait cycle per access
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      waitreq_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      waitreq_ff <= !((read || write) && waitreq_ff);
      if (cap_rd) begin
        rdata_ff <= 32'h0000_0000;
        case (address)
          tick_wdog_pkg::OFS_CONFIG:
            if (!cfg_ff[tick_wdog_pkg::CFG_LOCK_CFG]) rdata_ff[5:0] <= cfg_ff;
          tick_wdog_pkg::OFS_PRESCALE:
            if (!cfg_ff[tick_wdog_pkg::CFG_LOCK_PRE]) rdata_ff[2:0] <= div_ff;
          tick_wdog_pkg::OFS_RELOAD:
            if (!cfg_ff[tick_wdog_pkg::CFG_LOCK_TMR]) rdata_ff[15:0] <= reload_ff;
          tick_wdog_pkg::OFS_CTRL:
            if (!cfg_ff[tick_wdog_pkg::CFG_LOCK_TMR]) begin
              rdata_ff[2:0] <= {irq_en_ff, flag_ff, restart_ff};
            end
          default: rdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_ff <= tick_wdog_pkg::CFG_RST;
    end else if (wr_cfg) begin
      cfg_ff <= cfg_ff | wbyte[5:0];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_ff <= tick_wdog_pkg::DIV_RST;
      reload_ff <= tick_wdog_pkg::RELOAD_RST;
    end else begin
      if (wr_pre) div_ff <= wbyte[2:0];
      if (wr_rel_lo) reload_ff[7:0] <= writedata[7:0];
      if (wr_rel_hi) reload_ff[15:8] <= writedata[15:8];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      restart_ff <= 1'b0;
      irq_en_ff <= 1'b0;
      flag_ff <= 1'b0;
    end else begin
      if (wr_ctrl) irq_en_ff <= wbyte[tick_wdog_pkg::CSR_IRQ_EN];
      if (wr_ctrl && wbyte[tick_wdog_pkg::CSR_RESTART]) restart_ff <= 1'b1;
      else if (tick_en) restart_ff <= 1'b0;
      // flag set wins over read clear
      if (zero_evt) flag_ff <= 1'b1;
      else if (rd_ctrl) flag_ff <= 1'b0;
    end
  end

  // tick timer
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tmr_cnt_ff <= tick_wdog_pkg::RELOAD_RST;
      under_ff <= 1'b0;
      tick_irq_ff <= 1'b0;
    end else begin
      tick_irq_ff <= zero_evt && irq_en_ff;
      if (tick_en) begin
        under_ff <= zero_evt;
        if (restart_ff || tmr_cnt_ff == 16'h0000) tmr_cnt_ff <= reload_ff;
        else tmr_cnt_ff <= tmr_cnt_ff - 16'h0001;
      end
    end
  end

  // watchdog counter
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_reload_ff <= tick_wdog_pkg::WDCOUNT_RST;
      wd_cnt_ff <= tick_wdog_pkg::WDCOUNT_RST;
      wd_started_ff <= 1'b0;
    end else begin
      if (wr_wdc) begin
        wd_reload_ff <= wbyte;
        wd_cnt_ff <= wbyte;
        wd_started_ff <= 1'b1;
      end else if (key_ok) begin
        wd_cnt_ff <= wd_reload_ff;
        wd_started_ff <= 1'b1;
      end else if (wd_edge && wd_started_ff && wd_cnt_ff != 8'h00) begin
        wd_cnt_ff <= wd_cnt_ff - 8'h01;
      end
    end
  end

  // service marker per wdog clock, set wins
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      serviced_ff <= 1'b0;
    end else if (wr_key && cfg_ff[tick_wdog_pkg::CFG_KEY_EN]) begin
      serviced_ff <= 1'b1;
    end else if (wd_edge) begin
      serviced_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_err_ff <= 1'b0;
    end else if (wd_zero || key_bad || key_double) begin
      wd_err_ff <= 1'b1;
    end
  end

  AST_DIV_ONE: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (div_ff == 3'h0 && slow_edge) |-> tick_en)
    else $error("divide-by-one missed a tick");
  AST_DIV_32: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (div_ff == 3'h5 && tick_en) |-> pre_cnt_ff == 5'h1F)
    else $error("divide-by-32 ticked early");
  AST_RELOAD: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (tick_en && !restart_ff && tmr_cnt_ff == 16'h0000) |=> tmr_cnt_ff == $past(reload_ff))
    else $error("timer did not reload at underflow");
  AST_RESTART: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (tick_en && restart_ff && !wr_ctrl) |=> !restart_ff && tmr_cnt_ff == $past(reload_ff))
    else $error("restart not applied on tick");
  AST_FLAG_SET: assert property (@(posedge ref_clk) disable iff (!arst_n)
    zero_evt |=> flag_ff ##1 under_ff)
    else $error("zero event lost flag or pulse");
  AST_IRQ: assert property (@(posedge ref_clk) disable iff (!arst_n)
    tick_irq_ff |-> $past(zero_evt) && $past(irq_en_ff))
    else $error("tick interrupt without enabled zero");
  AST_KEY_RELOAD: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (key_ok && !wr_wdc) |=> wd_cnt_ff == $past(wd_reload_ff) && wd_started_ff)
    else $error("key write did not reload watchdog");
  AST_KEY_BAD: assert property (@(posedge ref_clk) disable iff (!arst_n)
    key_bad |=> wd_err_ff)
    else $error("bad key did not raise error");
  AST_KEY_TWICE: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (wr_key && cfg_ff[5] && serviced_ff) |=> wd_err_ff)
    else $error("double service not flagged");
  AST_KEY_OFF: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (wr_key && !cfg_ff[5] && !wd_zero && !wd_err_ff) |=> !wd_err_ff)
    else $error("ignored key write caused error");
  AST_WD_ZERO: assert property (@(posedge ref_clk) disable iff (!arst_n)
    wd_zero |=> wd_err_ff [*3])
    else $error("watchdog expiry not held as error");
  AST_STICKY: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ((cfg_ff & $past(cfg_ff)) == $past(cfg_ff)))
    else $error("config bit cleared");
  AST_PULSE_WIDTH: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (under_ff && !tick_en) |=> under_ff)
    else $error("underflow pulse shorter than a tick");
  AST_PULSE_END: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (under_ff && tick_en && !zero_evt) |=> !under_ff)
    else $error("underflow pulse longer than a tick");
  AST_RESTART_HOLD: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (restart_ff && !tick_en) |=> restart_ff)
    else $error("restart dropped before a tick");
  AST_FLAG_CLEAR: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (rd_ctrl && !zero_evt) |=> !flag_ff)
    else $error("status read did not clear flag");
  AST_IRQ_OFF: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !irq_en_ff |=> !tick_irq_ff)
    else $error("tick interrupt while disabled");
  AST_WDC_WRITE: assert property (@(posedge ref_clk) disable iff (!arst_n)
    wr_wdc |=> wd_cnt_ff == $past(wbyte) && wd_started_ff)
    else $error("count write did not start watchdog");
  AST_WD_STOPPED: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!wd_started_ff && !wd_err_ff && !key_bad && !key_double) |=> !wd_err_ff)
    else $error("stopped watchdog raised error");
  AST_TMR_DEC: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (tick_en && !restart_ff && tmr_cnt_ff != 16'h0000)
    |=> tmr_cnt_ff == $past(tmr_cnt_ff) - 16'h0001)
    else $error("timer did not step down on tick");
  AST_WD_DEC: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (wd_edge && wd_started_ff && !wr_wdc && !key_ok && wd_cnt_ff > tick_wdog_pkg::WD_ONE)
    |=> wd_cnt_ff == $past(wd_cnt_ff) - 8'h01)
    else $error("watchdog did not step down on its clock");

  COV_UNDERFLOW_IRQ: cover property (@(posedge ref_clk) disable iff (!arst_n)
    zero_evt && irq_en_ff ##1 tick_irq_ff);
  COV_KEY_SERVICE: cover property (@(posedge ref_clk) disable iff (!arst_n)
    key_ok && wd_started_ff);
  COV_WD_EXPIRE: cover property (@(posedge ref_clk) disable iff (!arst_n)
    $rose(wd_err_ff) && $past(wd_zero));
  COV_LOCKED_WRITE: cover property (@(posedge ref_clk) disable iff (!arst_n)
    acc_wr && address == tick_wdog_pkg::OFS_CONFIG && cfg_ff[0]);
  COV_WD_UNDERFLOW_CLK: cover property (@(posedge ref_clk) disable iff (!arst_n)
    wd_edge && wd_started_ff && !cfg_ff[tick_wdog_pkg::CFG_CLK_SEL]);
endmodule

// file: verif/tb.sv
`timescale 1ns/10ps
module tb;
  logic ref_clk;
  logic arst_n;
  logic low_speed_clock;
  logic [4:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [3:0] byteenable;
  logic [31:0] readdata;
  logic waitrequest;
  logic tick_irq;
  logic tick_underflow_pulse;
  logic wdog_reset_req;
  logic slow_run;
  logic [2:0] slow_cnt;
  int fail_count;
  int cmp_count;
  int cycles;
  int irq_n;
  int n0;
  int u0;
  int und_n;
  logic und_q;
  logic [31:0] q;

  tick_wdog_timer tick_wdog_timer_i (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .low_speed_clock(low_speed_clock),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .byteenable(byteenable),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .tick_irq(tick_irq),
    .tick_underflow_pulse(tick_underflow_pulse),
    .wdog_reset_req(wdog_reset_req)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // slow clock, eight ref cycles a period, parked low when stopped
  always @(posedge ref_clk) begin
    slow_cnt <= slow_run ? slow_cnt + 3'd1 : 3'd0;
    low_speed_clock <= slow_run & slow_cnt[2];
    if (tick_irq === 1'b1) irq_n <= irq_n + 1;
    und_q <= tick_underflow_pulse;
    if (tick_underflow_pulse === 1'b1 && und_q === 1'b0) und_n <= und_n + 1;
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count = fail_count + 1;
      stop_test();
    end
  end

  task automatic stop_test();
    if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
  endtask

  task automatic run_slow(input int n);
    slow_run <= 1'b1;
    repeat (n) @(posedge ref_clk);
    slow_run <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic req_is(input logic exp);
    repeat (2) @(posedge ref_clk);
    chk({31'd0, wdog_reset_req}, {31'd0, exp});
  endtask

  initial begin
    arst_n = 1'b0;
    low_speed_clock = 1'b0;
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    byteenable = 4'hF;
    slow_run = 1'b0;
    slow_cnt = 3'd0;
    fail_count = 0;
    cmp_count = 0;
    cycles = 0;
    irq_n = 0;
    und_n = 0;
    und_q = 1'b0;
    do_reset();
    bus(0, tick_wdog_pkg::OFS_CONFIG, 0); chk(q, 32'h0000_0000);
    bus(0, tick_wdog_pkg::OFS_PRESCALE, 0); chk(q, 32'h0000_0000);
    bus(0, tick_wdog_pkg::OFS_RELOAD, 0); chk(q, 32'h0000_FFFF);
    bus(0, tick_wdog_pkg::OFS_CTRL, 0); chk(q, 32'h0000_0000);
    bus(0, tick_wdog_pkg::OFS_WDCOUNT, 0); chk(q, 32'h0000_0000);
    bus(0, 5'h18, 0); chk(q, 32'h0000_0000);
    bus(1, tick_wdog_pkg::OFS_RELOAD, 32'h0000_1234);
    bus(0, tick_wdog_pkg::OFS_RELOAD, 0); chk(q, 32'h0000_1234);
    bus(1, tick_wdog_pkg::OFS_RELOAD, 32'h0000_0001);
    // reload 1 gives an irq every two ticks, tick every 2^d slow edges
    for (int d = 0; d < 6; d++) begin
      bus(1, tick_wdog_pkg::OFS_PRESCALE, d);
      bus(0, tick_wdog_pkg::OFS_PRESCALE, 0); chk(q, d);
      bus(1, tick_wdog_pkg::OFS_CTRL, 32'h0000_0005);
      run_slow(16 << d);
      n0 = irq_n;
      u0 = und_n;
      run_slow(160 << d);
      chk({31'd0, (irq_n - n0 >= 9) && (irq_n - n0 <= 11)}, 1);
      chk({31'd0, (und_n - u0 >= 9) && (und_n - u0 <= 11)}, 1);
    end
    bus(0, tick_wdog_pkg::OFS_CTRL, 0); chk(q, 32'h0000_0006);
    bus(0, tick_wdog_pkg::OFS_CTRL, 0); chk(q, 32'h0000_0004);
    bus(1, tick_wdog_pkg::OFS_PRESCALE, 32'h0000_0000);
    bus(1, tick_wdog_pkg::OFS_CTRL, 32'h0000_0002);
    n0 = irq_n;
    run_slow(80);
    chk(irq_n - n0, 0);
    bus(0, tick_wdog_pkg::OFS_CTRL, 0); chk(q, 32'h0000_0002);
    bus(1, tick_wdog_pkg::OFS_CONFIG, 32'h0000_0002);
    bus(1, tick_wdog_pkg::OFS_CONFIG, 32'h0000_0000);
    bus(0, tick_wdog_pkg::OFS_CONFIG, 0); chk(q, 32'h0000_0002);
    bus(1, tick_wdog_pkg::OFS_PRESCALE, 32'h0000_0001);
    bus(0, tick_wdog_pkg::OFS_PRESCALE, 0); chk(q, 32'h0000_0000);
    do_reset();
    bus(1, tick_wdog_pkg::OFS_CONFIG, 32'h0000_0010);
    run_slow(64);
    req_is(1'b0);
    bus(1, tick_wdog_pkg::OFS_WDCOUNT, 32'h0000_0003);
    req_is(1'b0);
    run_slow(64);
    req_is(1'b1);
    do_reset();
    bus(1, tick_wdog_pkg::OFS_RELOAD, 32'h0000_0001);
    bus(1, tick_wdog_pkg::OFS_CTRL, 32'h0000_0001);
    bus(1, tick_wdog_pkg::OFS_WDCOUNT, 32'h0000_0003);
    bus(1, tick_wdog_pkg::OFS_CONFIG, 32'h0000_002F);
    bus(1, tick_wdog_pkg::OFS_WDCOUNT, 32'h0000_0000);
    run_slow(32);
    req_is(1'b0);
    bus(1, tick_wdog_pkg::OFS_KEY, tick_wdog_pkg::SERVICE_KEY);
    run_slow(32);
    req_is(1'b0);
    run_slow(32);
    req_is(1'b1);
    do_reset();
    bus(1, tick_wdog_pkg::OFS_KEY, 32'h0000_0033);
    req_is(1'b0);
    bus(1, tick_wdog_pkg::OFS_CONFIG, 32'h0000_0020);
    bus(1, tick_wdog_pkg::OFS_KEY, tick_wdog_pkg::SERVICE_KEY);
    req_is(1'b0);
    bus(1, tick_wdog_pkg::OFS_KEY, tick_wdog_pkg::SERVICE_KEY);
    req_is(1'b1);
    do_reset();
    bus(1, tick_wdog_pkg::OFS_CONFIG, 32'h0000_0020);
    bus(1, tick_wdog_pkg::OFS_KEY, 32'h0000_0033);
    req_is(1'b1);
    stop_test();
  end
endmodule
